/* pkg/vic_cfg.svh */
// offsets, field positions, reset values and fixed codes of the controller
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_NSRC 48
`define VIC_VEC_BASE 9'h040
`define VIC_HOLE_MASK 48'h0000_0000_0600
`define VIC_HOLE_VA 9'h064
`define VIC_HOLE_VB 9'h068
`define VIC_NMI_VEC 16'h0066
`define VIC_MARK_SHORT 8'h00
`define VIC_MARK_WIDE 8'h01
`define A_PAGE_LO 8'h00
`define A_PAGE_HI 8'h01
`define A_PBASE 8'h02
`define A_CTRL 8'h03
`define A_LSP0 8'h04
`define A_LSP1 8'h05
`define A_LSP2 8'h06
`define A_SSP0 8'h07
`define A_SSP1 8'h08
`define A_STAT 8'h09
`define A_MASK 8'h0a
`define A_VLO 8'h0b
`define A_VHI 8'h0c
`define A_PRIO0 8'h10
`define N_PRIO 6
`define B_WIDE 0
`define B_MIXED 1
`define B_EN1 2
`define B_EN2 3
`define S_IRQ 0
`define S_NMI 1
`define RST_LSP 24'h000000
`define RST_SSP 16'h0000
`endif

/* pkg/vic_pkg.sv */
// types and shared decoding for the vectored interrupt controller
`include "vic_cfg.svh"
package vic_pkg;
    typedef logic [8:0] vec_t;
    typedef logic [23:0] addr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_VECT = 2'b10
    } seq_state_e;

    // vector of a priority slot: base plus four bytes per slot
    function automatic vec_t vector_of(input logic [5:0] idx);
        return `VIC_VEC_BASE + {1'b0, idx, 2'b00};
    endfunction : vector_of
endpackage : vic_pkg

/* pkg/prio_if.sv */
// request set and resolved vector between controller and resolver
`timescale 1ns/10ps
`default_nettype none
interface prio_if;
    logic [47:0] req;
    logic [47:0] level;
    logic any;
    vic_pkg::vec_t vec;
    modport ctl (output req, output level, input any, input vec);
    modport res (input req, input level, output any, output vec);
endinterface : prio_if
`default_nettype wire

/* hdl/priority_resolver.sv */
// two-level fixed priority resolver with registered vector
`timescale 1ns/10ps
`default_nettype none
module priority_resolver (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // async reset, high
    prio_if.res rs // requests in, vector out
);
    import vic_pkg::*;

    logic [47:0] eff;
    logic [47:0] pick;
    logic [5:0] idx;
    logic [47:0] pick_q;
    logic [5:0] idx_q;
    logic hit_q;
    logic lvl_q;

    //------------------------------------------------
    // selection
    //------------------------------------------------
    // empty slots masked, level one beats level zero, lowest slot wins
    always_comb begin
        eff = rs.req & ~`VIC_HOLE_MASK;
        pick = (|(eff & rs.level)) ? (eff & rs.level) : eff;
        idx = 6'h00;
        for (int i = 47; i >= 0; i--) begin
            if (pick[i]) begin
                idx = 6'(i);
            end
        end
    end

    // registered request and vector toward the core
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rs.any <= 1'b0;
            rs.vec <= 9'h000;
            idx_q <= 6'h00;
            pick_q <= 48'h0;
            hit_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            rs.any <= |eff;
            rs.vec <= (|eff) ? vector_of(idx) : 9'h000;
            idx_q <= idx;
            pick_q <= pick;
            hit_q <= |(eff & rs.level);
            lvl_q <= rs.level[idx];
        end
    end

    //------------------------------------------------
    // checks
    //------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_any_follows: assert property ((|eff) |=> rs.any)
        else $error("request not raised after active source");
    chk_idle_drop: assert property (!(|eff) |=> !rs.any)
        else $error("request held with no active source");
    chk_hole_skip: assert property (rs.any |-> rs.vec != `VIC_HOLE_VA && rs.vec != `VIC_HOLE_VB)
        else $error("vector placed in an empty slot");
    chk_lowest_slot: assert property (rs.any |-> pick_q[idx_q] &&
        (pick_q & ((48'h1 << idx_q) - 48'h1)) == 48'h0)
        else $error("not the highest priority source");
    chk_level_one: assert property (hit_q |-> lvl_q)
        else $error("level zero source beat level one");
endmodule : priority_resolver
`default_nettype wire

/* hdl/vectored_interrupt_controller.sv */
// vectored interrupt controller with the core-side vectoring sequence
//------------------------------------------------
//------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "vic_cfg.svh"
module vectored_interrupt_controller #(
    parameter int NUM_SRC = `VIC_NSRC // maskable slots, fixed layout
) (
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic sys_rst, // async reset, high
    input wire logic [15:0] periph_req, // on-chip peripheral requests, slots 0..15
    input wire logic [31:0] port_req, // port pin requests, slots 16..47
    input wire logic nmi_pin_n, // nonmaskable pin, falling edge
    input wire logic core_ready, // core at instruction boundary
    input wire vic_pkg::addr_t ret_pc, // return address to stack
    output logic irq_to_core, // maskable request to core
    output logic nmi_to_core, // nonmaskable request pending
    output vic_pkg::vec_t vector_index_bus, // vector of winning source
    output logic stack_we, // stack byte write
    output vic_pkg::addr_t stack_addr, // stack byte address
    output logic [7:0] stack_data, // stack byte
    output logic isr_start, // handler fetch begins
    output vic_pkg::addr_t addr_bus, // vector address on bus
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic irq_out // unmasked status pending
);
    import vic_pkg::*;

    if (NUM_SRC != `VIC_NSRC) begin : g_bad_num
        $error("slot count must match the fixed vector layout");
    end

    prio_if rs ();

    logic [15:0] page_q;
    logic [7:0] pbase_q;
    logic wide_q, mixed_q, en1_q, en2_q;
    logic [23:0] lsp_q;
    logic [15:0] ssp_q;
    logic [47:0] level_q;
    logic [1:0] stat_q, mask_q;
    logic nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_pend_q;
    seq_state_e st_q;
    logic [31:0] pb_q, pb_d;
    logic [2:0] cnt_q, cnt_d;
    logic short_q;
    addr_t vaddr_q, vaddr_d;
    logic take_nmi, take_irq, take, long_mode, nmi_fall;

    //------------------------------------------------
    // sources and resolver
    //------------------------------------------------
    // peripherals then port pins, unlatched
    assign rs.req = {port_req, periph_req};
    assign rs.level = level_q;

    priority_resolver u_res (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rs(rs)
    );

    assign irq_to_core = rs.any;
    assign vector_index_bus = rs.vec;
    assign nmi_to_core = nmi_pend_q;

    // pin synchroniser and falling edge catch
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_s1_q <= 1'b1;
            nmi_s2_q <= 1'b1;
            nmi_s3_q <= 1'b1;
        end else begin
            nmi_s1_q <= nmi_pin_n;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
        end
    end
    assign nmi_fall = nmi_s3_q & ~nmi_s2_q;

    // pending nonmaskable, a new edge beats the clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_fall) begin
            nmi_pend_q <= 1'b1;
        end else if (take_nmi) begin
            nmi_pend_q <= 1'b0;
        end
    end

    //------------------------------------------------
    // accept decision and vector formation
    //------------------------------------------------
    assign take_nmi = (st_q == ST_IDLE) && core_ready && nmi_pend_q;
    assign take_irq = (st_q == ST_IDLE) && core_ready && !nmi_pend_q
        && rs.any && en1_q;
    assign take = take_nmi | take_irq;
    assign long_mode = wide_q | mixed_q;

    // vector address and return bytes, high byte pushed first
    always_comb begin
        if (take_nmi) begin
            vaddr_d = long_mode ? {8'h00, `VIC_NMI_VEC} : {pbase_q, `VIC_NMI_VEC};
        end else if (long_mode) begin
            vaddr_d = {page_q[15:1], rs.vec};
        end else begin
            vaddr_d = {pbase_q, page_q[7:1], rs.vec};
        end
        unique case ({mixed_q, wide_q})
            2'b00: begin
                pb_d = {ret_pc[15:0], 16'h0000};
                cnt_d = 3'd2;
            end
            2'b01: begin
                pb_d = {ret_pc, 8'h00};
                cnt_d = 3'd3;
            end
            2'b10: begin
                pb_d = {ret_pc[15:0], `VIC_MARK_SHORT, 8'h00};
                cnt_d = 3'd3;
            end
            2'b11: begin
                pb_d = {ret_pc, `VIC_MARK_WIDE};
                cnt_d = 3'd4;
            end
        endcase
    end

    //------------------------------------------------
    // vectoring sequence
    //------------------------------------------------
    // idle, push return bytes, then drive the vector address
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            pb_q <= 32'h0;
            cnt_q <= 3'd0;
            short_q <= 1'b0;
            vaddr_q <= 24'h0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (take) begin
                        st_q <= ST_PUSH;
                        pb_q <= pb_d;
                        cnt_q <= cnt_d;
                        short_q <= !long_mode;
                        vaddr_q <= vaddr_d;
                    end
                end
                ST_PUSH: begin
                    pb_q <= {pb_q[23:0], 8'h00};
                    cnt_q <= cnt_q - 3'd1;
                    if (cnt_q == 3'd1) begin
                        st_q <= ST_VECT;
                    end
                end
                ST_VECT: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // stack byte writes, one per push cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stack_we <= 1'b0;
            stack_addr <= 24'h0;
            stack_data <= 8'h00;
        end else begin
            stack_we <= (st_q == ST_PUSH);
            stack_addr <= short_q ? {pbase_q, ssp_q - 16'h1} : lsp_q - 24'h1;
            stack_data <= pb_q[31:24];
        end
    end

    // vector address onto the bus as the handler starts
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            isr_start <= 1'b0;
            addr_bus <= 24'h0;
        end else begin
            isr_start <= (st_q == ST_VECT);
            if (st_q == ST_VECT) begin
                addr_bus <= vaddr_q;
            end
        end
    end

    //------------------------------------------------
    // register file
    //------------------------------------------------
    // software-only settings
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            page_q <= 16'h0000;
            pbase_q <= 8'h00;
            level_q <= 48'h0;
            mask_q <= 2'b00;
        end else if (reg_wr) begin
            if (reg_addr == `A_PAGE_LO) page_q[7:0] <= reg_wdata;
            if (reg_addr == `A_PAGE_HI) page_q[15:8] <= reg_wdata;
            if (reg_addr == `A_PBASE) pbase_q <= reg_wdata;
            if (reg_addr == `A_MASK) mask_q <= reg_wdata[1:0];
            for (int k = 0; k < `N_PRIO; k++) begin
                if (reg_addr == `A_PRIO0 + 8'(k)) begin
                    level_q[8*k +: 8] <= reg_wdata;
                end
            end
        end
    end

    // mode and enable flags, the accept overrides a write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wide_q <= 1'b0;
            mixed_q <= 1'b0;
            en1_q <= 1'b0;
            en2_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `A_CTRL) begin
                wide_q <= reg_wdata[`B_WIDE];
                mixed_q <= reg_wdata[`B_MIXED];
                en1_q <= reg_wdata[`B_EN1];
                en2_q <= reg_wdata[`B_EN2];
            end
            if (take_irq) begin
                en1_q <= 1'b0;
                en2_q <= 1'b0;
            end
            if (take_nmi) begin
                en1_q <= 1'b0;
            end
            if (take && mixed_q) begin
                wide_q <= 1'b1;
            end
        end
    end

    // stack pointers, decremented per pushed byte
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lsp_q <= `RST_LSP;
            ssp_q <= `RST_SSP;
        end else if (st_q == ST_PUSH) begin
            if (short_q) ssp_q <= ssp_q - 16'h1;
            else lsp_q <= lsp_q - 24'h1;
        end else if (reg_wr) begin
            if (reg_addr == `A_LSP0) lsp_q[7:0] <= reg_wdata;
            if (reg_addr == `A_LSP1) lsp_q[15:8] <= reg_wdata;
            if (reg_addr == `A_LSP2) lsp_q[23:16] <= reg_wdata;
            if (reg_addr == `A_SSP0) ssp_q[7:0] <= reg_wdata;
            if (reg_addr == `A_SSP1) ssp_q[15:8] <= reg_wdata;
        end
    end

    // sticky accept events, write one to clear, set wins
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= 2'b00;
        end else begin
            if (reg_wr && reg_addr == `A_STAT) stat_q <= stat_q & ~reg_wdata[1:0];
            if (take_irq) stat_q[`S_IRQ] <= 1'b1;
            if (take_nmi) stat_q[`S_NMI] <= 1'b1;
        end
    end
    assign irq_out = |(stat_q & mask_q);

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `A_PAGE_LO: reg_rdata <= page_q[7:0];
                `A_PAGE_HI: reg_rdata <= page_q[15:8];
                `A_PBASE: reg_rdata <= pbase_q;
                `A_CTRL: reg_rdata <= {4'h0, en2_q, en1_q, mixed_q, wide_q};
                `A_LSP0: reg_rdata <= lsp_q[7:0];
                `A_LSP1: reg_rdata <= lsp_q[15:8];
                `A_LSP2: reg_rdata <= lsp_q[23:16];
                `A_SSP0: reg_rdata <= ssp_q[7:0];
                `A_SSP1: reg_rdata <= ssp_q[15:8];
                `A_STAT: reg_rdata <= {6'h00, stat_q};
                `A_MASK: reg_rdata <= {6'h00, mask_q};
                `A_VLO: reg_rdata <= rs.vec[7:0];
                `A_VHI: reg_rdata <= {5'h00, nmi_pend_q, rs.any, rs.vec[8]};
                8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15:
                    reg_rdata <= level_q[8*(reg_addr - `A_PRIO0) +: 8];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    //------------------------------------------------
    // checks
    //------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_nmi_edge: assert property (nmi_fall |=> nmi_pend_q)
        else $error("pin edge not held pending");
    chk_nmi_first: assert property (core_ready && st_q == ST_IDLE && nmi_pend_q
        && rs.any |-> take_nmi && !take_irq)
        else $error("maskable served ahead of nonmaskable");
    chk_ief_clear: assert property (take_irq |=> !en1_q && !en2_q)
        else $error("enable flags not cleared on accept");
    chk_short_vec: assert property (take_irq && !wide_q && !mixed_q |-> ##4 (isr_start
        && addr_bus == {$past(pbase_q, 4), $past(page_q[7:1], 4), $past(rs.vec, 4)}))
        else $error("short mode vector address wrong");
    chk_short_push: assert property (take && !wide_q && !mixed_q |=> ##1
        (stack_we && stack_addr[23:16] == $past(pbase_q, 2))[*2] ##1 !stack_we)
        else $error("short stack push count wrong");
    chk_long_vec: assert property (take_irq && long_mode |=>
        vaddr_q == {$past(page_q[15:1]), $past(rs.vec)})
        else $error("long mode vector address wrong");
    chk_wide_push: assert property (take && wide_q && !mixed_q |=> ##1 stack_we[*3]
        ##1 (!stack_we && isr_start))
        else $error("wide mode push sequence wrong");
    chk_mixed_mark: assert property (take && mixed_q && !wide_q |=> wide_q ##3
        (stack_we && stack_data == `VIC_MARK_SHORT))
        else $error("mixed mode marker or mode switch wrong");

    cov_nmi_take: cover property (take_nmi);
    cov_short_take: cover property (take_irq && !wide_q && !mixed_q);
    cov_wide_take: cover property (take_irq && wide_q && !mixed_q);
    cov_mixed_take: cover property (take_irq && mixed_q && !wide_q);
endmodule : vectored_interrupt_controller
`default_nettype wire

/* tb/core_model.sv */
// processor core stand-in that offers boundaries and records pushed bytes
`timescale 1ns/10ps
`default_nettype none
module core_model #(
    parameter logic [23:0] RET_PC = 24'hc3b2a1 // return address offered
) (
    input wire logic clk_sys, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic go, // bench lets the core accept
    input wire logic stack_we, // stack byte write
    input wire vic_pkg::addr_t stack_addr, // stack byte address
    input wire logic [7:0] stack_data, // stack byte
    input wire logic isr_start, // handler fetch begins
    output logic core_ready, // boundary offered
    output vic_pkg::addr_t ret_pc, // return address
    output logic [31:0] pushed, // bytes in push order
    output vic_pkg::addr_t low_addr, // last, lowest byte address
    output logic [2:0] n_pushed // bytes seen
);
    import vic_pkg::*;
    logic done_q;
    // return address only valid at a boundary, inverted otherwise
    assign ret_pc = core_ready ? RET_PC : ~RET_PC;
    // offer a boundary until the handler starts
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            core_ready <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= go & (done_q | isr_start);
            core_ready <= go & ~done_q & ~isr_start;
        end
    end
    // collect stack bytes of one vectoring
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst || !go) begin
            pushed <= 32'h0;
            low_addr <= 24'h0;
            n_pushed <= 3'h0;
        end else if (stack_we) begin
            pushed <= {pushed[23:0], stack_data};
            low_addr <= stack_addr;
            n_pushed <= n_pushed + 3'h1;
        end
    end
endmodule : core_model
`default_nettype wire

/* tb/vectored_interrupt_controller_bench.sv */
// self-checking bench of the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_controller_bench;
    import vic_pkg::*;
    localparam logic [15:0] PAGE = 16'h1235; // lsb set on purpose
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [47:0] sources = 48'h0;
    logic nmi_pin_n = 1'b1;
    logic go = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic core_ready, irq_to_core, nmi_to_core, stack_we, isr_start, irq_out;
    logic [7:0] stack_data, reg_rdata, rv;
    logic [31:0] pushed;
    logic [2:0] n_pushed;
    addr_t ret_pc, stack_addr, addr_bus, low_addr;
    vec_t vector_index_bus;
    int mismatches = 0;
    int comparisons = 0;
    //------------------------------------------------
    // clock, design and core
    //------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;
    vectored_interrupt_controller dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .periph_req(sources[15:0]),
        .port_req(sources[47:16]), .nmi_pin_n(nmi_pin_n), .core_ready(core_ready),
        .ret_pc(ret_pc), .irq_to_core(irq_to_core), .nmi_to_core(nmi_to_core),
        .vector_index_bus(vector_index_bus), .stack_we(stack_we), .stack_addr(stack_addr),
        .stack_data(stack_data), .isr_start(isr_start), .addr_bus(addr_bus),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_out(irq_out)
    );
    core_model core (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .stack_we(stack_we),
        .stack_addr(stack_addr), .stack_data(stack_data), .isr_start(isr_start),
        .core_ready(core_ready), .ret_pc(ret_pc), .pushed(pushed), .low_addr(low_addr),
        .n_pushed(n_pushed)
    );
    //------------------------------------------------
    // shared tasks
    //------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // load stacks, page base and page, then run one vectoring
    task automatic vec_run(input logic [47:0] src, input logic [7:0] ctrl);
        int i;
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h10);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h00);
        wr(8'h08, 8'h01);
        wr(8'h02, 8'h7a);
        wr(8'h00, PAGE[7:0]);
        wr(8'h01, PAGE[15:8]);
        wr(8'h03, ctrl);
        @(posedge clk_sys);
        sources <= src;
        repeat (4) @(posedge clk_sys);
        go <= 1'b1;
        for (i = 0; i < 40 && isr_start !== 1'b1; i++) begin
            tick(1);
        end
        if (isr_start !== 1'b1) begin
            mismatches++;
            $display("ERROR isr_start expected 1 seen %b", isr_start);
            tally_and_finish();
        end
    endtask : vec_run
    // release core and sources once the handler has started
    task automatic vec_end(input logic [7:0] exp_ctrl);
        @(posedge clk_sys);
        go <= 1'b0;
        sources <= 48'h0;
        nmi_pin_n <= 1'b1;
        rd(8'h03, rv);
        chk("ctrl after", exp_ctrl, rv);
    endtask : vec_end
    //------------------------------------------------
    // scenarios
    //------------------------------------------------
    task automatic test_reset();
        int a;
        for (a = 0; a <= 8'h0c; a++) begin
            rd(a[7:0], rv);
            chk("reset reg", 8'h00, rv);
        end
        rd(8'h20, rv);
        chk("unmapped", 8'h00, rv);
        chk("irq idle", 1'b0, irq_to_core);
        $display("test reset done");
    endtask : test_reset
    task automatic test_priority();
        int n;
        for (n = 0; n < 48; n++) begin
            @(posedge clk_sys);
            sources <= 48'h1 << n;
            tick(2);
            chk("irq single", (n != 9 && n != 10), irq_to_core);
            if (n != 9 && n != 10) chk("vector", 9'h040 + 9'(n * 4), vector_index_bus);
        end
        @(posedge clk_sys);
        sources <= 48'h8000_0000_0608;
        tick(2);
        chk("lowest slot wins", 9'h04c, vector_index_bus);
        wr(8'h15, 8'h80);
        tick(2);
        chk("level one wins", 9'h0fc, vector_index_bus);
        wr(8'h15, 8'h00);
        sources <= 48'h0;
        tick(2);
        chk("irq drops", 1'b0, irq_to_core);
        $display("test priority done");
    endtask : test_priority
    task automatic test_mode00();
        wr(8'h0a, 8'h01);
        vec_run(48'h8, 8'h0c);
        chk("short addr", {8'h7a, PAGE[7:1], 9'h04c}, addr_bus);
        chk("short bytes", 32'h0000b2a1, pushed);
        chk("short count", 3'h2, n_pushed);
        chk("short low", 24'h7a00fe, low_addr);
        vec_end(8'h00);
        rd(8'h09, rv);
        chk("status", 8'h01, rv);
        chk("irq_out set", 1'b1, irq_out);
        wr(8'h09, 8'h01);
        tick(1);
        chk("irq_out cleared", 1'b0, irq_out);
        $display("test mode00 done");
    endtask : test_mode00
    task automatic test_wide();
        vec_run(48'h8, 8'h05);
        chk("wide addr", {PAGE[15:1], 9'h04c}, addr_bus);
        chk("wide bytes", 32'h00c3b2a1, pushed);
        chk("wide low", 24'h000ffd, low_addr);
        vec_end(8'h01);
        $display("test wide done");
    endtask : test_wide
    task automatic test_mixed();
        vec_run(48'h8, 8'h06);
        chk("mixed addr", {PAGE[15:1], 9'h04c}, addr_bus);
        chk("mixed bytes", 32'h00b2a100, pushed);
        chk("mixed count", 3'h3, n_pushed);
        vec_end(8'h03);
        $display("test mixed done");
    endtask : test_mixed
    task automatic test_nmi();
        @(posedge clk_sys);
        nmi_pin_n <= 1'b0;
        vec_run(48'h1, 8'h0d);
        chk("nmi first", 24'h000066, addr_bus);
        chk("nmi taken", 1'b0, nmi_to_core);
        vec_end(8'h09);
        $display("test nmi done");
    endtask : test_nmi
    //------------------------------------------------
    // main sequence
    //------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        test_reset();
        test_priority();
        test_mode00();
        test_wide();
        test_mixed();
        test_nmi();
        tally_and_finish();
    end
endmodule : vectored_interrupt_controller_bench
`default_nettype wire
